/* mwp_cfg.svh */
`ifndef MWP_CFG_SVH
`define MWP_CFG_SVH

// Unlock keys, in the order they must be written
`define MWP_KEY_FIRST 16'habcd
`define MWP_KEY_SECOND 16'h4321

// Lock enable position in the oscillator selection word, and its reset value
`define MWP_LOCK_BIT 6
`define MWP_LOCK_RST 1'b1

// Output control word fields
`define MWP_OC_SWAP 0
`define MWP_OC_FLT_HI 1
`define MWP_OC_FLT_LO 2
`define MWP_OC_RST 16'h0000

// Fault control word fields; reset selects the safety fault in latched mode
`define MWP_FC_MODE 1:0
`define MWP_FC_SRC 3:2
`define MWP_FC_RST 16'h0000
`define MWP_FM_LATCH 2'h0
`define MWP_FM_CYCLE 2'h1
`define MWP_FS_SAFETY 2'h0
`define MWP_FS_A 2'h1
`define MWP_FS_B 2'h2

// Counter constants
`define MWP_CNT_ZERO 16'h0000
`define MWP_CNT_STEP 16'h0001
`define MWP_PS_ZERO 4'h0
`define MWP_PS_STEP 4'h1

`endif

/* mwp_pkg.sv */
package mwp_pkg;

    // Unlock sequence states; code 2'b11 is illegal
    typedef enum logic [1:0] {
        MWP_LK_IDLE = 2'b00,
        MWP_LK_KEY1 = 2'b01,
        MWP_LK_OPEN = 2'b10
    } mwp_lock_t;

    // Target of a register access
    typedef enum logic [1:0] {
        MWP_TGT_KEY = 2'b00,
        MWP_TGT_OUT = 2'b01,
        MWP_TGT_FLT = 2'b10,
        MWP_TGT_OTHER = 2'b11
    } mwp_tgt_t;

    // One register access, valid for the cycle that stb is high
    typedef struct packed {
        logic stb;
        logic we;
        mwp_tgt_t tgt;
        logic [2:0] idx;
        logic [15:0] wdata;
    } mwp_sfr_req_t;

    // Per-generator timing, in clock cycles
    typedef struct packed {
        logic [15:0] period;
        logic [15:0] duty;
        logic [15:0] phase;
        logic [15:0] trig;
    } mwp_gen_cfg_t;

    // Time base and sync configuration
    typedef struct packed {
        logic sync_en;
        logic sync_src;
        logic sync_pol;
        logic sync_out_en;
        logic sev_base;
        logic [3:0] sev_ps;
    } mwp_tb_cfg_t;

    // Generator state
    typedef struct packed {
        logic [15:0] cnt;
        logic pwm;
        logic trig;
        logic pstart;
    } mwp_gen_state_t;

endpackage : mwp_pkg

/* mwp_gen.sv */
`timescale 1ns/10ps
`include "mwp_cfg.svh"

module mwp_gen
(
    input wire logic clock,               // System clock
    input wire logic rst,                 // Synchronous reset, active high
    input wire logic enable,              // Module enable
    input wire logic msync,               // Master time base rollover pulse
    input mwp_pkg::mwp_gen_cfg_t cfg,     // Period, duty, phase, trigger point
    output logic pwm,                     // Raw high-side level
    output logic trig,                    // ADC trigger pulse
    output logic pstart                   // Own period start pulse
);
    import mwp_pkg::*;

    mwp_gen_state_t s;
    mwp_gen_state_t next_s;

    // Counter runs on its own period but is realigned by the master base
    always_comb
    begin
        next_s = s;
        next_s.pstart = 1'b0;
        if (!enable)
        begin
            next_s.cnt = `MWP_CNT_ZERO;
            next_s.pwm = 1'b0;
            next_s.trig = 1'b0;
        end
        else
        begin
            if (msync)
            begin
                next_s.cnt = cfg.phase;
                next_s.pstart = 1'b1;
            end
            else if (s.cnt >= cfg.period)
            begin
                next_s.cnt = `MWP_CNT_ZERO;
                next_s.pstart = 1'b1;
            end
            else
            begin
                next_s.cnt = s.cnt + `MWP_CNT_STEP;
            end
            // Compare against the new count so level and count stay in step
            next_s.pwm = next_s.cnt < cfg.duty;
            next_s.trig = next_s.cnt == cfg.trig;
        end
    end

    // State register
    always_ff @(posedge clock)
    begin
        if (rst)
            s <= '0;
        else
            s <= next_s;
    end

    assign pwm = s.pwm;
    assign trig = s.trig;
    assign pstart = s.pstart;

endmodule : mwp_gen

/* mwp_core.sv */
`timescale 1ns/10ps
`include "mwp_cfg.svh"

// Behaviour
// - Drive up to twelve outputs, a high and low pin per generator.
// - Each generator has its own period and duty for its pair.
// - One master time base realigns every generator.
// - Duty, phase and period adjust in steps of one timing unit.
// - Enabled fault inputs force outputs to the programmed safe levels.
// - Each generator pulses an ADC trigger at a programmable count.
// - Special event trigger comes from one of two selectable master bases.
// - Two sync inputs can realign the primary time base.
// - Two sync outputs mark the time base rollovers for outside devices.
// - High and low outputs of a generator can swap pins.
// - The safety fault input stays owned by this block through reset.
// - Reset selects the safety fault, latched, so outputs start safe.
// - Fault mode field is writable whatever the safety pin level.
// - Output and fault control are write protected when lock bit six set.
// - Lock defaults on; a zero lock bit removes protection.
// - Unlock needs first key then second key in consecutive key writes.
// - The protected write must be the very next access after the keys.
// - Any other access during the sequence voids the unlock.
// - One unlock grants exactly one protected write.
module mwp_core
#(
    parameter int NGEN = 6                          // Number of generators
)
(
    input wire logic CLOCK,                         // System clock
    input wire logic RST,                           // Synchronous reset, active high
    input wire logic MODULE_EN,                     // Module enable
    input wire logic [15:0] LOCK_CFG_WORD,          // Oscillator selection word
    input mwp_pkg::mwp_sfr_req_t SFR,               // Register access
    input mwp_pkg::mwp_gen_cfg_t GEN_CFG [NGEN],    // Per-generator timing
    input wire logic [15:0] PRI_PERIOD,             // Primary base period
    input wire logic [15:0] SEC_PERIOD,             // Secondary base period
    input wire logic [15:0] SEV_CMP,                // Special event compare
    input mwp_pkg::mwp_tb_cfg_t TB_CFG,             // Time base and sync setup
    input wire logic SYNC_IN_A,                     // External sync input a
    input wire logic SYNC_IN_B,                     // External sync input b
    input wire logic FAULT_IN_A,                    // Fault input a, active high
    input wire logic FAULT_IN_B,                    // Fault input b, active high
    input wire logic SAFETY_FAULT_IN_N,             // Safety fault, active low
    output logic [NGEN-1:0] GEN_HIGH_OUT,           // High-side outputs
    output logic [NGEN-1:0] GEN_LOW_OUT,            // Low-side outputs
    output logic [NGEN-1:0] ADC_TRIG,               // Per-generator ADC triggers
    output logic SPECIAL_TRIG,                      // Special event trigger
    output logic SYNC_OUT_A,                        // Primary base sync out
    output logic SYNC_OUT_B,                        // Secondary base sync out
    output logic [NGEN-1:0] FAULT_ACTIVE,           // Held fault per generator
    output logic LOCK_OPEN,                         // One protected write pending
    output logic WRITE_REFUSED,                     // Protected write ignored
    output logic SAFETY_FAULT_OWNED                 // Safety pin held by this block
);
    import mwp_pkg::*;

    typedef struct packed {
        mwp_lock_t lock;
        logic lock_en;
        logic [NGEN-1:0][15:0] oc;
        logic [NGEN-1:0][15:0] fc;
        logic [NGEN-1:0] flt;
        logic [15:0] pri_cnt;
        logic [15:0] sec_cnt;
        logic [3:0] ps_cnt;
        logic sync_a_q;
        logic sync_b_q;
        logic [NGEN-1:0] hi;
        logic [NGEN-1:0] lo;
        logic [NGEN-1:0] trig;
        logic sev;
        logic so_a;
        logic so_b;
        logic refused;
        logic owned;
        logic open;
    } mwp_core_state_t;

    mwp_core_state_t s;
    mwp_core_state_t next_s;

    logic [NGEN-1:0] gen_pwm;
    logic [NGEN-1:0] gen_trig;
    logic [NGEN-1:0] gen_pstart;
    logic sync_a_eff;
    logic sync_b_eff;
    logic ext_sync;
    logic pri_roll;
    logic sec_roll;
    logic sev_match;
    logic acc;
    logic prot_wr;
    logic wr_grant;

    // A key write of the given value
    function automatic logic is_key(mwp_sfr_req_t r, logic [15:0] key);
        return r.stb & r.we & (r.tgt == MWP_TGT_KEY) & (r.wdata == key);
    endfunction : is_key

    // Fault source decode; the unused code selects no source
    function automatic logic fault_src(logic [1:0] sel, logic a, logic b, logic safe);
        logic v;
        v = 1'b0;
        case (sel)
            `MWP_FS_SAFETY: v = safe;
            `MWP_FS_A: v = a;
            `MWP_FS_B: v = b;
            default: v = 1'b0;
        endcase
        return v;
    endfunction : fault_src

    // Sync inputs are edge sensitive, after polarity correction
    assign sync_a_eff = SYNC_IN_A ^ TB_CFG.sync_pol;
    assign sync_b_eff = SYNC_IN_B ^ TB_CFG.sync_pol;
    assign ext_sync = TB_CFG.sync_en & (TB_CFG.sync_src ? (sync_b_eff & ~s.sync_b_q)
                                                        : (sync_a_eff & ~s.sync_a_q));

    // Master time base events
    assign pri_roll = MODULE_EN & (ext_sync | (s.pri_cnt >= PRI_PERIOD));
    assign sec_roll = MODULE_EN & (s.sec_cnt >= SEC_PERIOD);
    assign sev_match = MODULE_EN
                     & ((TB_CFG.sev_base ? s.sec_cnt : s.pri_cnt) == SEV_CMP);

    // Protected write qualification; reads of protected registers never need a key
    assign acc = SFR.stb;
    assign prot_wr = SFR.stb & SFR.we
                   & ((SFR.tgt == MWP_TGT_OUT) | (SFR.tgt == MWP_TGT_FLT))
                   & (int'(SFR.idx) < NGEN);
    assign wr_grant = prot_wr & (~s.lock_en | (s.lock == MWP_LK_OPEN));

    // Generators share the primary rollover as their alignment pulse
    generate
        for (genvar g = 0; g < NGEN; g++)
        begin : gen_pwm_ch
            mwp_gen u_gen (
                .clock(CLOCK),
                .rst(RST),
                .enable(MODULE_EN),
                .msync(pri_roll),
                .cfg(GEN_CFG[g]),
                .pwm(gen_pwm[g]),
                .trig(gen_trig[g]),
                .pstart(gen_pstart[g])
            );
        end
    endgenerate

    // Next state of the whole block
    always_comb
    begin
        logic src;
        logic [1:0] mode;
        logic fc_wr;
        logic fault_on;
        logic a;
        logic b;
        src = 1'b0;
        mode = `MWP_FM_LATCH;
        fc_wr = 1'b0;
        fault_on = 1'b0;
        a = 1'b0;
        b = 1'b0;
        next_s = s;

        // Lock bit is a live configuration level, not software writable
        next_s.lock_en = LOCK_CFG_WORD[`MWP_LOCK_BIT];
        next_s.owned = 1'b1;
        next_s.refused = prot_wr & ~wr_grant;
        next_s.sync_a_q = sync_a_eff;
        next_s.sync_b_q = sync_b_eff;

        // Key sequence; any access other than the expected one drops back to idle
        unique case (s.lock)
            MWP_LK_IDLE:
            begin
                if (is_key(SFR, `MWP_KEY_FIRST))
                    next_s.lock = MWP_LK_KEY1;
            end
            MWP_LK_KEY1:
            begin
                if (acc)
                    next_s.lock = is_key(SFR, `MWP_KEY_SECOND) ? MWP_LK_OPEN
                                                               : MWP_LK_IDLE;
            end
            MWP_LK_OPEN:
            begin
                if (acc)
                    next_s.lock = MWP_LK_IDLE;
            end
            default:
            begin
                next_s.lock = MWP_LK_IDLE;
            end
        endcase
        // Grant flag is its own flop so the pin has no decode in front of it
        next_s.open = (next_s.lock == MWP_LK_OPEN);

        // Granted writes land in full; the mode field is never gated by the pin
        if (wr_grant)
        begin
            if (SFR.tgt == MWP_TGT_OUT)
                next_s.oc[SFR.idx] = SFR.wdata;
            else
                next_s.fc[SFR.idx] = SFR.wdata;
        end

        // Primary and secondary master time bases
        if (!MODULE_EN)
        begin
            next_s.pri_cnt = `MWP_CNT_ZERO;
            next_s.sec_cnt = `MWP_CNT_ZERO;
        end
        else
        begin
            next_s.pri_cnt = pri_roll ? `MWP_CNT_ZERO : s.pri_cnt + `MWP_CNT_STEP;
            next_s.sec_cnt = sec_roll ? `MWP_CNT_ZERO : s.sec_cnt + `MWP_CNT_STEP;
        end

        // Special event postscaler: fires on every (sev_ps + 1)th match
        next_s.sev = 1'b0;
        if (!MODULE_EN)
        begin
            next_s.ps_cnt = `MWP_PS_ZERO;
        end
        else if (sev_match)
        begin
            if (s.ps_cnt >= TB_CFG.sev_ps)
            begin
                next_s.sev = 1'b1;
                next_s.ps_cnt = `MWP_PS_ZERO;
            end
            else
            begin
                next_s.ps_cnt = s.ps_cnt + `MWP_PS_STEP;
            end
        end

        // Sync outputs idle low when disabled, else a rollover pulse at polarity
        next_s.so_a = TB_CFG.sync_out_en & (pri_roll ^ TB_CFG.sync_pol);
        next_s.so_b = TB_CFG.sync_out_en & (sec_roll ^ TB_CFG.sync_pol);

        // Per generator fault hold, swap and safe override
        for (int i = 0; i < NGEN; i++)
        begin
            src = fault_src(s.fc[i][`MWP_FC_SRC], FAULT_IN_A, FAULT_IN_B,
                            ~SAFETY_FAULT_IN_N);
            mode = s.fc[i][`MWP_FC_MODE];
            fc_wr = wr_grant & (SFR.tgt == MWP_TGT_FLT) & (int'(SFR.idx) == i);
            // Set wins over clear, so a fault that is still present survives
            if (mode == `MWP_FM_LATCH)
                next_s.flt[i] = src | (s.flt[i] & ~fc_wr);
            else if (mode == `MWP_FM_CYCLE)
                next_s.flt[i] = src | (s.flt[i] & ~gen_pstart[i]);
            else
                next_s.flt[i] = 1'b0;
            // Live source forces at once; the hold covers the release
            fault_on = s.flt[i] | (src & ((mode == `MWP_FM_LATCH) | (mode == `MWP_FM_CYCLE)));
            a = gen_pwm[i];
            b = MODULE_EN & ~gen_pwm[i];
            if (s.oc[i][`MWP_OC_SWAP])
            begin
                a = MODULE_EN & ~gen_pwm[i];
                b = gen_pwm[i];
            end
            if (fault_on)
            begin
                a = s.oc[i][`MWP_OC_FLT_HI];
                b = s.oc[i][`MWP_OC_FLT_LO];
            end
            next_s.hi[i] = a;
            next_s.lo[i] = b;
            next_s.trig[i] = gen_trig[i] & ~fault_on;
        end
    end

    // State register; reset leaves every generator latched on the safety fault
    always_ff @(posedge CLOCK)
    begin
        if (RST)
        begin
            s <= '0;
            s.lock <= MWP_LK_IDLE;
            s.lock_en <= `MWP_LOCK_RST;
            s.oc <= {NGEN{`MWP_OC_RST}};
            s.fc <= {NGEN{`MWP_FC_RST}};
            s.flt <= '1;
            s.owned <= 1'b1;
        end
        else
        begin
            s <= next_s;
        end
    end

    // Outputs straight from the state register
    assign GEN_HIGH_OUT = s.hi;
    assign GEN_LOW_OUT = s.lo;
    assign ADC_TRIG = s.trig;
    assign SPECIAL_TRIG = s.sev;
    assign SYNC_OUT_A = s.so_a;
    assign SYNC_OUT_B = s.so_b;
    assign FAULT_ACTIVE = s.flt;
    assign LOCK_OPEN = s.open;
    assign WRITE_REFUSED = s.refused;
    assign SAFETY_FAULT_OWNED = s.owned;

endmodule : mwp_core

/* mwp_core_monitor.sv */
`timescale 1ns/10ps
`include "mwp_cfg.svh"

// Watches lock, refusal, reset and pairing behaviour at the core's ports
module mwp_core_monitor
import mwp_pkg::*;
#(
    parameter int NGEN = 6 // Generators
)
(
    input wire logic CLOCK, // Clock
    input wire logic RST, // Reset
    input wire logic MODULE_EN, // Enable
    input wire logic [15:0] LOCK_CFG_WORD, // Lock word
    input mwp_pkg::mwp_sfr_req_t SFR, // Access
    input mwp_pkg::mwp_tb_cfg_t TB_CFG, // Time base setup
    input wire logic [NGEN-1:0] GEN_HIGH_OUT, // High side
    input wire logic [NGEN-1:0] GEN_LOW_OUT, // Low side
    input wire logic [NGEN-1:0] FAULT_ACTIVE, // Fault flags
    input wire logic SPECIAL_TRIG, // Special event
    input wire logic SYNC_OUT_A, // Sync out a
    input wire logic SYNC_OUT_B, // Sync out b
    input wire logic LOCK_OPEN, // Grant pending
    input wire logic WRITE_REFUSED, // Refusal pulse
    input wire logic SAFETY_FAULT_OWNED // Safety pin owned
);
    mwp_lock_t lk;
    logic key1;
    logic key2;
    logic prot;
    // Key and protected write decodes
    assign key1 = SFR.stb && SFR.we && SFR.tgt == MWP_TGT_KEY && SFR.wdata == `MWP_KEY_FIRST;
    assign key2 = SFR.stb && SFR.we && SFR.tgt == MWP_TGT_KEY && SFR.wdata == `MWP_KEY_SECOND;
    assign prot = SFR.stb && SFR.we && SFR.tgt inside {MWP_TGT_OUT, MWP_TGT_FLT} && SFR.idx < NGEN;
    // Reference key sequence; any access off the path falls back to idle
    always_ff @(posedge CLOCK)
    begin
        if (RST)
            lk <= MWP_LK_IDLE;
        else if (lk == MWP_LK_IDLE && key1)
            lk <= MWP_LK_KEY1;
        else if (lk == MWP_LK_KEY1 && key2)
            lk <= MWP_LK_OPEN;
        else if (SFR.stb)
            lk <= MWP_LK_IDLE;
    end
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (RST);
    AST_LOCK_SEQ: assert property (LOCK_OPEN == (lk == MWP_LK_OPEN))
        else $error("lock open disagrees with key sequence");
    AST_ONE_GRANT: assert property (LOCK_OPEN && SFR.stb |=> !LOCK_OPEN)
        else $error("grant survived an access");
    AST_REFUSE: assert property (prot && !LOCK_OPEN
        && $past(LOCK_CFG_WORD[`MWP_LOCK_BIT]) |=> WRITE_REFUSED)
        else $error("locked write not refused");
    AST_UNLOCKED: assert property (prot && !$past(LOCK_CFG_WORD[`MWP_LOCK_BIT])
        && !$past(RST) |=> !WRITE_REFUSED)
        else $error("write refused with lock off");
    AST_REFUSE_CAUSE: assert property (WRITE_REFUSED
        |-> $past(prot) && !$past(LOCK_OPEN))
        else $error("refusal without locked write");
    AST_OWNED: assert property (SAFETY_FAULT_OWNED)
        else $error("safety pin released");
    AST_RESET_SAFE: assert property ($fell(RST) |-> FAULT_ACTIVE == {NGEN{1'b1}})
        else $error("faults not latched after reset");
    AST_SYNC_QUIET: assert property (!TB_CFG.sync_out_en && !$past(TB_CFG.sync_out_en)
        |-> !SYNC_OUT_A && !SYNC_OUT_B)
        else $error("sync out while disabled");
    AST_PAIR: assert property ((MODULE_EN && FAULT_ACTIVE == '0)[*4]
        |-> GEN_LOW_OUT == ~GEN_HIGH_OUT)
        else $error("output pair not complementary");
    // Main scenarios reached
    cover property (LOCK_OPEN && SFR.stb);
    cover property (WRITE_REFUSED);
    cover property (SPECIAL_TRIG);
endmodule : mwp_core_monitor

bind mwp_core mwp_core_monitor #(.NGEN(NGEN)) mwp_core_monitor_inst (.CLOCK(CLOCK), .RST(RST),
    .MODULE_EN(MODULE_EN), .LOCK_CFG_WORD(LOCK_CFG_WORD), .SFR(SFR), .TB_CFG(TB_CFG),
    .GEN_HIGH_OUT(GEN_HIGH_OUT), .GEN_LOW_OUT(GEN_LOW_OUT), .FAULT_ACTIVE(FAULT_ACTIVE),
    .SPECIAL_TRIG(SPECIAL_TRIG), .SYNC_OUT_A(SYNC_OUT_A), .SYNC_OUT_B(SYNC_OUT_B),
    .LOCK_OPEN(LOCK_OPEN), .WRITE_REFUSED(WRITE_REFUSED), .SAFETY_FAULT_OWNED(SAFETY_FAULT_OWNED));

/* mwp_far_end.sv */
`timescale 1ns/10ps

// Far side: sync source, fault sensors and the pulled-up safety pin
module mwp_far_end
(
    input wire logic clock, // Clock
    input wire logic sync_run, // Emit sync pulses
    input wire logic [1:0] flt, // Sensor levels b, a
    input wire logic trip, // Pull safety pin low
    output logic sync_in_a, // Sync line a
    output logic sync_in_b, // Sync line b
    output logic fault_in_a, // Fault line a
    output logic fault_in_b, // Fault line b
    output logic safety_fault_in_n // Safety pin
);
    logic [2:0] cnt = 3'h0;
    // One pulse in six cycles, shorter than the base period so it always wins
    always @(posedge clock)
        cnt <= (!sync_run || cnt == 3'h5) ? 3'h0 : cnt + 3'h1;
    // Sync lines rest low outside a run
    assign sync_in_a = sync_run && cnt == 3'h5;
    assign sync_in_b = sync_run && cnt == 3'h5;
    assign fault_in_a = flt[0];
    assign fault_in_b = flt[1];
    // Pull-up keeps the pin high unless tripped
    assign safety_fault_in_n = !trip;
endmodule : mwp_far_end

/* tb_mwp_core.sv */
`timescale 1ns/10ps
`include "mwp_cfg.svh"

// Self-checking bench for the core: lock, faults and timing
module tb_mwp_core;
    import mwp_pkg::*;
    localparam int NG = 6;
    logic CLOCK = 1'b0;
    logic RST = 1'b1;
    logic MODULE_EN = 1'b0;
    logic [15:0] LOCK_CFG_WORD = 16'h0040;
    mwp_sfr_req_t SFR = '0;
    mwp_gen_cfg_t GEN_CFG [NG];
    logic [15:0] PRI_PERIOD = 16'h0009;
    logic [15:0] SEC_PERIOD = 16'h0004;
    logic [15:0] SEV_CMP = 16'h0003;
    mwp_tb_cfg_t TB_CFG = '0;
    logic SYNC_IN_A, SYNC_IN_B, FAULT_IN_A, FAULT_IN_B, SAFETY_FAULT_IN_N;
    logic [NG-1:0] GEN_HIGH_OUT, GEN_LOW_OUT, ADC_TRIG, FAULT_ACTIVE;
    logic SPECIAL_TRIG, SYNC_OUT_A, SYNC_OUT_B, LOCK_OPEN, WRITE_REFUSED, SAFETY_FAULT_OWNED;
    logic sync_run = 1'b0;
    logic [1:0] flt = 2'h0;
    logic trip = 1'b0;
    int bad_count = 0;
    int n_tests = 0;

    always #2 CLOCK = ~CLOCK;

    mwp_core #(.NGEN(NG)) mwp_core_inst (.CLOCK(CLOCK), .RST(RST), .MODULE_EN(MODULE_EN),
        .LOCK_CFG_WORD(LOCK_CFG_WORD), .SFR(SFR), .GEN_CFG(GEN_CFG), .PRI_PERIOD(PRI_PERIOD),
        .SEC_PERIOD(SEC_PERIOD), .SEV_CMP(SEV_CMP), .TB_CFG(TB_CFG), .SYNC_IN_A(SYNC_IN_A),
        .SYNC_IN_B(SYNC_IN_B), .FAULT_IN_A(FAULT_IN_A), .FAULT_IN_B(FAULT_IN_B),
        .SAFETY_FAULT_IN_N(SAFETY_FAULT_IN_N), .GEN_HIGH_OUT(GEN_HIGH_OUT),
        .GEN_LOW_OUT(GEN_LOW_OUT), .ADC_TRIG(ADC_TRIG), .SPECIAL_TRIG(SPECIAL_TRIG),
        .SYNC_OUT_A(SYNC_OUT_A), .SYNC_OUT_B(SYNC_OUT_B), .FAULT_ACTIVE(FAULT_ACTIVE),
        .LOCK_OPEN(LOCK_OPEN), .WRITE_REFUSED(WRITE_REFUSED),
        .SAFETY_FAULT_OWNED(SAFETY_FAULT_OWNED));
    mwp_far_end mwp_far_end_inst (.clock(CLOCK), .sync_run(sync_run), .flt(flt), .trip(trip),
        .sync_in_a(SYNC_IN_A), .sync_in_b(SYNC_IN_B), .fault_in_a(FAULT_IN_A),
        .fault_in_b(FAULT_IN_B), .safety_fault_in_n(SAFETY_FAULT_IN_N));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One access presented just after an edge, held through the next edge
    task automatic put(input mwp_tgt_t t, input logic [2:0] i, input logic [15:0] d);
        @(posedge CLOCK);
        #1;
        SFR = '{1'b1, 1'b1, t, i, d};
    endtask : put

    task automatic rest(input int n);
        repeat (n)
        begin
            @(posedge CLOCK);
            #1;
            SFR.stb = 1'b0;
        end
    endtask : rest

    task automatic unlock();
        put(MWP_TGT_KEY, 3'h0, `MWP_KEY_FIRST);
        put(MWP_TGT_KEY, 3'h0, `MWP_KEY_SECOND);
    endtask : unlock

    task automatic t_reset();
        chk(16'(FAULT_ACTIVE), 16'({NG{1'b1}}));
        chk(16'(SAFETY_FAULT_OWNED), 16'h0001);
        rest(3);
        chk(16'({GEN_HIGH_OUT, GEN_LOW_OUT}), 16'h0000);
        $display("reset test done");
    endtask : t_reset

    task automatic t_lock();
        put(MWP_TGT_FLT, 3'h0, 16'h0000);
        rest(1);
        chk(16'(WRITE_REFUSED), 16'h0001);
        rest(1);
        chk(16'(FAULT_ACTIVE[0]), 16'h0001);
        // Clear every latched fault, one unlock each, safety pin held high
        for (int g = 0; g < NG; g++)
        begin
            unlock();
            put(MWP_TGT_FLT, 3'(g), 16'h0000);
            chk(16'(LOCK_OPEN), 16'h0001);
            rest(1);
            chk(16'({LOCK_OPEN, WRITE_REFUSED}), 16'h0000);
            rest(1);
            chk(16'(FAULT_ACTIVE[g]), 16'h0000);
        end
        $display("lock test done");
    endtask : t_lock

    task automatic t_broken();
        put(MWP_TGT_KEY, 3'h0, `MWP_KEY_FIRST);
        put(MWP_TGT_OTHER, 3'h0, 16'h0000);
        put(MWP_TGT_KEY, 3'h0, `MWP_KEY_SECOND);
        put(MWP_TGT_OUT, 3'h0, 16'h0001);
        rest(1);
        chk(16'(WRITE_REFUSED), 16'h0001);
        put(MWP_TGT_KEY, 3'h0, `MWP_KEY_FIRST);
        put(MWP_TGT_KEY, 3'h0, 16'h1234);
        put(MWP_TGT_KEY, 3'h0, `MWP_KEY_SECOND);
        put(MWP_TGT_OUT, 3'h0, 16'h0001);
        rest(1);
        chk(16'(WRITE_REFUSED), 16'h0001);
        unlock();
        put(MWP_TGT_OUT, 3'h0, 16'h0000);
        put(MWP_TGT_OUT, 3'h1, 16'h0001);
        rest(1);
        chk(16'(WRITE_REFUSED), 16'h0001);
        $display("broken sequence test done");
    endtask : t_broken

    task automatic t_swap();
        LOCK_CFG_WORD = 16'h0000;
        rest(2);
        put(MWP_TGT_OUT, 3'h0, 16'h0001);
        rest(1);
        chk(16'(WRITE_REFUSED), 16'h0000);
        rest(4);
        chk(16'({GEN_HIGH_OUT[0], GEN_LOW_OUT[0]}), 16'h0001);
        chk(16'({GEN_HIGH_OUT[2:1], GEN_LOW_OUT[2:1]}), 16'h0009);
        LOCK_CFG_WORD = 16'h0040;
        $display("swap test done");
    endtask : t_swap

    // Pulse counts over 40 cycles: base a 10 cycles, base b 5, generator 5
    task automatic t_timing();
        int na;
        int nb;
        int ns;
        int nt;
        for (int k = 0; k < 4; k++)
        begin
            TB_CFG = '{k > 1, k == 3, k == 1, 1'b1, k == 1, (k > 1) ? 4'h0 : 4'h1};
            SEV_CMP = (k > 1) ? 16'h0008 : 16'h0003;
            sync_run = k > 1;
            rest(12);
            na = 0;
            nb = 0;
            ns = 0;
            nt = 0;
            repeat (40)
            begin
                rest(1);
                na += SYNC_OUT_A;
                nb += SYNC_OUT_B;
                ns += SPECIAL_TRIG;
                nt += ADC_TRIG[0];
            end
            chk(16'(ns), (k > 1) ? 16'h0000 : 16'(2 + 2 * k));
            // Inverted polarity in pass one: the line rests high, low at each rollover
            chk(16'(nb), (k == 1) ? 16'h0020 : 16'h0008);
            if (k < 2)
            begin
                chk(16'(na), (k == 1) ? 16'h0024 : 16'h0004);
                chk(16'(nt), 16'h0008);
            end
            else
            begin
                // Sync every six cycles: six or seven rollovers and triggers, never eight
                chk(16'(na / 6), 16'h0001);
                chk(16'(nt / 6 + nt / 8), 16'h0001);
            end
        end
        sync_run = 1'b0;
        TB_CFG = '0;
        $display("timing test done");
    endtask : t_timing

    task automatic t_fault();
        unlock();
        put(MWP_TGT_FLT, 3'h2, 16'h0005);
        rest(1);
        flt = 2'h1;
        rest(2);
        chk(16'({FAULT_ACTIVE[2], GEN_HIGH_OUT[2], GEN_LOW_OUT[2]}), 16'h0004);
        flt = 2'h0;
        rest(8);
        chk(16'(FAULT_ACTIVE[2]), 16'h0000);
        trip = 1'b1;
        rest(2);
        chk(16'(FAULT_ACTIVE[3]), 16'h0001);
        unlock();
        put(MWP_TGT_FLT, 3'h3, 16'h0002);
        rest(2);
        chk(16'(FAULT_ACTIVE[3]), 16'h0000);
        $display("fault test done");
    endtask : t_fault

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : conclude

    initial
    begin
        for (int g = 0; g < NG; g++)
            GEN_CFG[g] = '{16'h0004, (g == 1) ? 16'h0000 : 16'h0005, 16'h0000, 16'h0002};
        repeat (5) @(posedge CLOCK);
        #1;
        RST = 1'b0;
        MODULE_EN = 1'b1;
        t_reset();
        t_lock();
        t_broken();
        t_swap();
        t_timing();
        t_fault();
        conclude();
    end

    // Bound on the whole run
    initial
    begin
        #100000;
        bad_count++;
        conclude();
    end
endmodule : tb_mwp_core
